// File: hw/ebc_pkg.sv
// Shared constants and types of the external bus area controller
package ebc_pkg;
	localparam int AW    = 24;
	localparam int DW    = 16;
	localparam int RW    = 8;
	localparam int AREAS = 8;
	localparam int NMST  = 3;

	// Register indexes; byte address is four times the index
	localparam logic [15:0] IDX_AREA_SEL = 16'hff5f;
	localparam logic [15:0] IDX_BUS_WID  = 16'hffec;
	localparam logic [15:0] IDX_ACC_LEN  = 16'hffed;
	localparam logic [15:0] IDX_WAIT_CFG = 16'hffee;
	localparam logic [15:0] IDX_WAIT_ENA = 16'hffef;
	localparam logic [15:0] IDX_BUS_REL  = 16'hfff3;

	localparam logic [7:0] RST_AREA_SEL = 8'h0f;
	localparam logic [7:0] ABW_ALL_8    = 8'hff;
	localparam logic [7:0] ABW_ALL_16   = 8'h00;
	localparam logic [7:0] RST_ACC_LEN  = 8'hff;
	localparam logic [7:0] RST_WAIT_CFG = 8'hf3;
	localparam logic [7:0] RST_WAIT_ENA = 8'hff;
	localparam logic [7:0] RST_BUS_REL  = 8'hfe;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [3:0] RSVD_ONES    = 4'hf;

	// Wait scheme field codes
	localparam logic [1:0] WS_PROG = 2'h0;
	localparam logic [1:0] WS_NONE = 2'h1;
	localparam logic [1:0] WS_PIN1 = 2'h2;
	localparam logic [1:0] WS_AUTO = 2'h3;
	localparam logic [1:0] WCNT_ZERO = 2'h0;
	localparam logic [1:0] WCNT_ONE  = 2'h1;

	localparam int AREA_LSB_1M  = 17;
	localparam int AREA_LSB_16M = 21;
	localparam int FIXED_SEL    = 4;
	localparam int PERMIT_BIT   = 0;

	localparam logic [2:0] MODE_2 = 3'h2;
	localparam logic [2:0] MODE_3 = 3'h3;
	localparam logic [2:0] MODE_4 = 3'h4;
	localparam logic [2:0] MODE_5 = 3'h5;
	localparam logic [2:0] MODE_6 = 3'h6;

	localparam int M_CPU  = 0;
	localparam int M_DMA  = 1;
	localparam int M_RFSH = 2;

	localparam logic [2:0] INIT_FIRE = 3'h3;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_GNT  = 7'h02,
		S_T1   = 7'h04,
		S_T2   = 7'h08,
		S_TW   = 7'h10,
		S_T3   = 7'h20,
		S_REL  = 7'h40
	} ebc_state_t;
endpackage : ebc_pkg

// File: hw/ebc_ctrl.sv
// External bus area controller: areas, waits, arbiter, AXI4-Lite registers
//
// How it works
// - Address space splits into eight areas, each with own settings.
// - Area size is 128 kbytes in 1-Mbyte modes, 2 Mbytes otherwise.
// - Each area has its own active-low select strobe during its accesses.
// - Each area may be an 8-bit or a 16-bit data bus region.
// - Each area may use two-state or three-state bus cycles.
// - Four wait schemes: programmable, pin auto-wait, pin wait modes 0 and 1.
// - Zero to three wait states may be inserted without any pin request.
// - Arbiter gives the bus to at most one of CPU, DMA, refresh, external.
// - Address strobe is low while a valid address is driven.
// - Read strobe is low during any external read cycle.
// - Upper write strobe is low while valid data sits on upper lanes.
// - Lower write strobe is low while valid data sits on lower lanes.
// - Wait pin low stretches accesses to three-state areas.
// - Bus request pin answered by acknowledge once the bus is released.
// - All width bits one gives 8-bit bus mode, upper lanes only.
// - Any width bit zero gives 16-bit bus mode, all lanes.
// - Reset or hardware standby load width reg per mode; software standby keeps it.
// - Width bit zero means 16-bit area, one means 8-bit area.
// - Length bit zero means two states, one (reset) means three states.
// - Wait count field picks zero to three waits, three after reset.
// - Cleared wait enable bit puts that area in pin wait mode zero.
// - Bus release starts only while release permit bit is one.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ebc_ctrl (
	input  wire logic                CLK_I,
	input  wire logic                RST_N_I,
	input  wire logic [2:0]          MODE_I,
	input  wire logic                HW_STBY_N_I,
	input  wire logic [2:0]          MST_REQ_I,
	output logic      [2:0]          MST_GNT_O,
	input  wire logic [23:0]         ACC_ADDR_I,
	input  wire logic                ACC_WR_I,
	input  wire logic [1:0]          ACC_BE_I,
	input  wire logic [15:0]         ACC_WDATA_I,
	output logic                     ACC_DONE_O,
	output logic      [15:0]         ACC_RDATA_O,
	output logic      [23:0]         EXT_ADDR_O,
	output logic                     EXT_OE_O,
	output logic      [15:0]         DATA_O,
	output logic                     DATA_OE_O,
	input  wire logic [15:0]         DATA_I,
	output logic      [7:0]          AREA_SEL_N_O,
	output logic                     ADDR_STROBE_N_O,
	output logic                     READ_STROBE_N_O,
	output logic                     UPPER_WRITE_STROBE_N_O,
	output logic                     LOWER_WRITE_STROBE_N_O,
	input  wire logic                WAIT_N_I,
	input  wire logic                BUS_REQUEST_IN_N_I,
	output logic                     BUS_ACK_N_O,
	output logic                     BUS8_MODE_O,
	input  wire logic [31:0]         S_AXI_AWADDR_I,
	input  wire logic                S_AXI_AWVALID_I,
	output logic                     S_AXI_AWREADY_O,
	input  wire logic [31:0]         S_AXI_WDATA_I,
	input  wire logic [3:0]          S_AXI_WSTRB_I,
	input  wire logic                S_AXI_WVALID_I,
	output logic                     S_AXI_WREADY_O,
	output logic      [1:0]          S_AXI_BRESP_O,
	output logic                     S_AXI_BVALID_O,
	input  wire logic                S_AXI_BREADY_I,
	input  wire logic [31:0]         S_AXI_ARADDR_I,
	input  wire logic                S_AXI_ARVALID_I,
	output logic                     S_AXI_ARREADY_O,
	output logic      [31:0]         S_AXI_RDATA_O,
	output logic      [1:0]          S_AXI_RRESP_O,
	output logic                     S_AXI_RVALID_O,
	input  wire logic                S_AXI_RREADY_I
);

	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic [1:0]  rst_sync_reg;
	logic        rst_n;
	logic [21:0] pin_s1_reg;
	logic [21:0] pin_s2_reg;
	logic [15:0] data_s;
	logic        wait_low;
	logic        bus_request_in_low;
	logic        stby;
	logic [2:0]  mode_s;

	always_ff @(posedge CLK_I or negedge RST_N_I)
		if (!RST_N_I)
			rst_sync_reg <= '0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	assign rst_n = rst_sync_reg[1];

	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
		begin
			pin_s1_reg <= '1;
			pin_s2_reg <= '1;
		end
		else
		begin
			pin_s1_reg <= {DATA_I, WAIT_N_I, BUS_REQUEST_IN_N_I, HW_STBY_N_I, MODE_I};
			pin_s2_reg <= pin_s1_reg;
		end
	assign {data_s, wait_low, bus_request_in_low, stby, mode_s} =
		{pin_s2_reg[21:6], ~pin_s2_reg[5], ~pin_s2_reg[4], ~pin_s2_reg[3], pin_s2_reg[2:0]};

	// ****************************************
	// Mode capture after reset release
	// ****************************************
	logic [2:0] init_sh_reg;
	logic [2:0] mode_reg;
	logic       init_load;
	logic       mode16;
	logic       addr_en_mode;

	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
			init_sh_reg <= '0;
		else
			init_sh_reg <= {init_sh_reg[1:0], 1'b1};

	// Straps are read only once the synchronisers hold them
	assign init_load = (init_sh_reg == ebc_pkg::INIT_FIRE) | stby;

	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
			mode_reg <= '0;
		else if (init_load)
			mode_reg <= mode_s;

	assign mode16 = (mode_reg == ebc_pkg::MODE_3) | (mode_reg == ebc_pkg::MODE_4) |
		(mode_reg == ebc_pkg::MODE_5) | (mode_reg == ebc_pkg::MODE_6);
	assign addr_en_mode = (mode_reg == ebc_pkg::MODE_3) | (mode_reg == ebc_pkg::MODE_4) |
		(mode_reg == ebc_pkg::MODE_6);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic [31:0] aw_addr_reg;
	logic [7:0]  w_byte_reg;
	logic        w_lane0_reg;
	logic        aw_got_reg;
	logic        w_got_reg;
	logic        wr_do;
	logic [31:0] rd_val;

	function automatic logic at(input logic [31:0] a, input logic [15:0] idx);
		at = (a == {14'h0000, idx, 2'h0});
	endfunction : at

	function automatic logic mapped(input logic [31:0] a);
		mapped = at(a, ebc_pkg::IDX_AREA_SEL) | at(a, ebc_pkg::IDX_BUS_WID) |
			at(a, ebc_pkg::IDX_ACC_LEN) | at(a, ebc_pkg::IDX_WAIT_CFG) |
			at(a, ebc_pkg::IDX_WAIT_ENA) | at(a, ebc_pkg::IDX_BUS_REL);
	endfunction : mapped

	assign wr_do = aw_got_reg & w_got_reg & !S_AXI_BVALID_O;

	// One write in flight; ready returns only after the response is taken
	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
		begin
			S_AXI_AWREADY_O <= 1'b1;
			S_AXI_WREADY_O  <= 1'b1;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= ebc_pkg::AXI_OKAY;
			aw_got_reg      <= 1'b0;
			w_got_reg       <= 1'b0;
			aw_addr_reg     <= '0;
			w_byte_reg      <= '0;
			w_lane0_reg     <= 1'b0;
		end
		else
		begin
			if (S_AXI_AWVALID_I & S_AXI_AWREADY_O)
			begin
				aw_addr_reg     <= S_AXI_AWADDR_I;
				aw_got_reg      <= 1'b1;
				S_AXI_AWREADY_O <= 1'b0;
			end
			if (S_AXI_WVALID_I & S_AXI_WREADY_O)
			begin
				w_byte_reg     <= S_AXI_WDATA_I[7:0];
				w_lane0_reg    <= S_AXI_WSTRB_I[0];
				w_got_reg      <= 1'b1;
				S_AXI_WREADY_O <= 1'b0;
			end
			if (wr_do)
			begin
				aw_got_reg     <= 1'b0;
				w_got_reg      <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O  <= mapped(aw_addr_reg) ? ebc_pkg::AXI_OKAY : ebc_pkg::AXI_SLVERR;
			end
			else if (S_AXI_BVALID_O & S_AXI_BREADY_I)
			begin
				S_AXI_BVALID_O  <= 1'b0;
				S_AXI_AWREADY_O <= 1'b1;
				S_AXI_WREADY_O  <= 1'b1;
			end
		end

	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
		begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= '0;
			S_AXI_RRESP_O   <= ebc_pkg::AXI_OKAY;
		end
		else if (S_AXI_ARVALID_I & S_AXI_ARREADY_O)
		begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b1;
			S_AXI_RDATA_O   <= rd_val;
			S_AXI_RRESP_O   <= mapped(S_AXI_ARADDR_I) ? ebc_pkg::AXI_OKAY : ebc_pkg::AXI_SLVERR;
		end
		else if (S_AXI_RVALID_O & S_AXI_RREADY_I)
		begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
		end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [7:0] area_select_output_enable_reg;
	logic [7:0] area_bus_width_reg;
	logic [7:0] area_access_length_reg;
	logic [7:0] wait_configuration_reg;
	logic [7:0] wait_control_enable_reg;
	logic [7:0] bus_release_control_reg;
	logic [1:0] wait_scheme_field;
	logic [1:0] wait_count_field;
	logic       release_permit_bit;
	logic       wr_lane;

	assign wr_lane = wr_do & w_lane0_reg;
	assign wait_scheme_field  = wait_configuration_reg[3:2];
	assign wait_count_field   = wait_configuration_reg[1:0];
	assign release_permit_bit = bus_release_control_reg[ebc_pkg::PERMIT_BIT];

	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
		begin
			area_select_output_enable_reg <= ebc_pkg::RST_AREA_SEL;
			area_bus_width_reg            <= ebc_pkg::ABW_ALL_8;
			area_access_length_reg        <= ebc_pkg::RST_ACC_LEN;
			wait_configuration_reg        <= ebc_pkg::RST_WAIT_CFG;
			wait_control_enable_reg       <= ebc_pkg::RST_WAIT_ENA;
			bus_release_control_reg       <= ebc_pkg::RST_BUS_REL;
		end
		else if (init_load)
		begin
			// Software standby is not an input here, so nothing else reloads
			area_bus_width_reg <= ((mode_s == ebc_pkg::MODE_2) | (mode_s == ebc_pkg::MODE_4)) ?
				ebc_pkg::ABW_ALL_16 : ebc_pkg::ABW_ALL_8;
			area_select_output_enable_reg <= ebc_pkg::RST_AREA_SEL;
			area_access_length_reg        <= ebc_pkg::RST_ACC_LEN;
			wait_configuration_reg        <= ebc_pkg::RST_WAIT_CFG;
			wait_control_enable_reg       <= ebc_pkg::RST_WAIT_ENA;
			bus_release_control_reg       <= ebc_pkg::RST_BUS_REL;
		end
		else if (wr_lane)
		begin
			if (at(aw_addr_reg, ebc_pkg::IDX_AREA_SEL))
				area_select_output_enable_reg <= {w_byte_reg[7:4], ebc_pkg::RSVD_ONES};
			else if (at(aw_addr_reg, ebc_pkg::IDX_BUS_WID))
				area_bus_width_reg <= w_byte_reg;
			else if (at(aw_addr_reg, ebc_pkg::IDX_ACC_LEN))
				area_access_length_reg <= w_byte_reg;
			else if (at(aw_addr_reg, ebc_pkg::IDX_WAIT_CFG))
				wait_configuration_reg <= {ebc_pkg::RSVD_ONES, w_byte_reg[3:0]};
			else if (at(aw_addr_reg, ebc_pkg::IDX_WAIT_ENA))
				wait_control_enable_reg <= w_byte_reg;
			else if (at(aw_addr_reg, ebc_pkg::IDX_BUS_REL))
				bus_release_control_reg <= {addr_en_mode ? w_byte_reg[7:5] : bus_release_control_reg[7:5],
					ebc_pkg::RSVD_ONES, w_byte_reg[0]};
		end

	always_comb
	begin
		rd_val = '0;
		if (at(S_AXI_ARADDR_I, ebc_pkg::IDX_AREA_SEL))
			rd_val[7:0] = area_select_output_enable_reg;
		else if (at(S_AXI_ARADDR_I, ebc_pkg::IDX_BUS_WID))
			rd_val[7:0] = area_bus_width_reg;
		else if (at(S_AXI_ARADDR_I, ebc_pkg::IDX_ACC_LEN))
			rd_val[7:0] = area_access_length_reg;
		else if (at(S_AXI_ARADDR_I, ebc_pkg::IDX_WAIT_CFG))
			rd_val[7:0] = wait_configuration_reg;
		else if (at(S_AXI_ARADDR_I, ebc_pkg::IDX_WAIT_ENA))
			rd_val[7:0] = wait_control_enable_reg;
		else if (at(S_AXI_ARADDR_I, ebc_pkg::IDX_BUS_REL))
			rd_val[7:0] = bus_release_control_reg;
	end

	// ****************************************
	// Area decode and bus cycle sequencer
	// ****************************************
	ebc_pkg::ebc_state_t st_reg, st_next;
	logic [23:0] lat_addr_reg;
	logic        lat_wr_reg;
	logic [1:0]  lat_be_reg;
	logic [15:0] lat_wdata_reg;
	logic [23:0] cur_addr;
	logic        cur_wr;
	logic [1:0]  cur_be;
	logic [15:0] cur_wdata;
	logic        done_due_reg;
	logic        rd_cap_reg;
	logic        rd_hi_reg;
	logic        rd_nar_reg;
	logic [2:0]  area;
	logic        narrow;
	logic        three;
	logic        pin_hold;
	logic        need_prog;
	logic        fin;
	logic [1:0]  wcnt_reg, wcnt_next;
	logic        hi_reg, hi_next;
	logic        pend_reg, pend_next;
	logic [2:0]  gnt_next;
	logic [7:0]  sel_en;

	assign cur_addr = (st_reg == ebc_pkg::S_GNT) ? ACC_ADDR_I : lat_addr_reg;
	assign cur_wr   = (st_reg == ebc_pkg::S_GNT) ? ACC_WR_I : lat_wr_reg;
	assign cur_be   = (st_reg == ebc_pkg::S_GNT) ? ACC_BE_I : lat_be_reg;
	assign cur_wdata = (st_reg == ebc_pkg::S_GNT) ? ACC_WDATA_I : lat_wdata_reg;
	assign area     = mode16 ? cur_addr[ebc_pkg::AREA_LSB_16M +: 3] : cur_addr[ebc_pkg::AREA_LSB_1M +: 3];
	assign narrow   = area_bus_width_reg[area];
	assign three    = area_access_length_reg[area];
	// Wait enable off falls back to pin wait mode zero
	assign pin_hold = !wait_control_enable_reg[area] | (wait_scheme_field == ebc_pkg::WS_PIN1);
	assign need_prog = wait_control_enable_reg[area] & (wait_count_field != ebc_pkg::WCNT_ZERO) &
		((wait_scheme_field == ebc_pkg::WS_PROG) | (wait_scheme_field == ebc_pkg::WS_PIN1) |
		((wait_scheme_field == ebc_pkg::WS_AUTO) & wait_low));
	assign fin = ((st_reg == ebc_pkg::S_T2) & !three) | (st_reg == ebc_pkg::S_T3);

	always_comb
	begin
		st_next   = st_reg;
		wcnt_next = wcnt_reg;
		hi_next   = hi_reg;
		pend_next = pend_reg;
		gnt_next  = MST_GNT_O;
		case (st_reg)
			ebc_pkg::S_IDLE:
			begin
				gnt_next = '0;
				// Grant stands until read data has crossed the synchroniser
				if (done_due_reg)
					gnt_next = MST_GNT_O;
				else if (stby)
					st_next = ebc_pkg::S_IDLE;
				else if (release_permit_bit & bus_request_in_low)
					st_next = ebc_pkg::S_REL;
				else if (|MST_REQ_I & !ACC_DONE_O)
				begin
					st_next = ebc_pkg::S_GNT;
					// Fixed priority: refresh, then DMA, then CPU
					if (MST_REQ_I[ebc_pkg::M_RFSH])
						gnt_next[ebc_pkg::M_RFSH] = 1'b1;
					else if (MST_REQ_I[ebc_pkg::M_DMA])
						gnt_next[ebc_pkg::M_DMA] = 1'b1;
					else
						gnt_next[ebc_pkg::M_CPU] = 1'b1;
				end
			end
			ebc_pkg::S_GNT:
			begin
				st_next   = ebc_pkg::S_T1;
				hi_next   = ACC_BE_I[1];
				pend_next = narrow & (&ACC_BE_I);
			end
			ebc_pkg::S_T1:
				st_next = ebc_pkg::S_T2;
			ebc_pkg::S_T2:
				if (three)
				begin
					if (need_prog | (pin_hold & wait_low))
					begin
						st_next   = ebc_pkg::S_TW;
						wcnt_next = need_prog ? wait_count_field - ebc_pkg::WCNT_ONE : ebc_pkg::WCNT_ZERO;
					end
					else
						st_next = ebc_pkg::S_T3;
				end
			ebc_pkg::S_TW:
				if (wcnt_reg != ebc_pkg::WCNT_ZERO)
					wcnt_next = wcnt_reg - ebc_pkg::WCNT_ONE;
				else if (!(pin_hold & wait_low))
					st_next = ebc_pkg::S_T3;
			ebc_pkg::S_REL:
				if (!bus_request_in_low)
					st_next = ebc_pkg::S_IDLE;
			default:
				st_next = ebc_pkg::S_IDLE;
		endcase
		// Word to an 8-bit area takes a second cycle for the odd byte
		if (fin & pend_reg)
		begin
			st_next   = ebc_pkg::S_T1;
			hi_next   = 1'b0;
			pend_next = 1'b0;
		end
		else if (fin)
			st_next = ebc_pkg::S_IDLE;
	end

	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
		begin
			st_reg    <= ebc_pkg::S_IDLE;
			wcnt_reg  <= ebc_pkg::WCNT_ZERO;
			hi_reg    <= 1'b0;
			pend_reg  <= 1'b0;
			MST_GNT_O <= '0;
		end
		else
		begin
			st_reg    <= st_next;
			wcnt_reg  <= wcnt_next;
			hi_reg    <= hi_next;
			pend_reg  <= pend_next;
			MST_GNT_O <= gnt_next;
		end

	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
		begin
			lat_addr_reg  <= '0;
			lat_wr_reg    <= 1'b0;
			lat_be_reg    <= '0;
			lat_wdata_reg <= '0;
		end
		else if (st_reg == ebc_pkg::S_GNT)
		begin
			lat_addr_reg  <= ACC_ADDR_I;
			lat_wr_reg    <= ACC_WR_I;
			lat_be_reg    <= ACC_BE_I;
			lat_wdata_reg <= ACC_WDATA_I;
		end

	// Pin data lags two edges, so capture and done follow the last state by one edge
	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
		begin
			done_due_reg <= 1'b0;
			rd_cap_reg   <= 1'b0;
			rd_hi_reg    <= 1'b0;
			rd_nar_reg   <= 1'b0;
			ACC_DONE_O   <= 1'b0;
			ACC_RDATA_O  <= '0;
		end
		else
		begin
			done_due_reg <= fin & !pend_reg;
			rd_cap_reg   <= fin & !lat_wr_reg;
			rd_hi_reg    <= hi_reg;
			rd_nar_reg   <= narrow;
			ACC_DONE_O   <= done_due_reg;
			if (rd_cap_reg & !rd_nar_reg)
				ACC_RDATA_O <= data_s;
			else if (rd_cap_reg & rd_hi_reg)
				ACC_RDATA_O[15:8] <= data_s[15:8];
			else if (rd_cap_reg)
				ACC_RDATA_O[7:0] <= data_s[15:8];
		end

	// ****************************************
	// External pin drivers
	// ****************************************
	logic act;
	logic wstb;

	assign act  = (st_next == ebc_pkg::S_T1) | (st_next == ebc_pkg::S_T2) |
		(st_next == ebc_pkg::S_TW) | (st_next == ebc_pkg::S_T3);
	assign wstb = act & cur_wr & (three ? (st_next != ebc_pkg::S_T1) :
		((st_next == ebc_pkg::S_T1) | (st_next == ebc_pkg::S_T2)));

	// Areas below four always have select outputs
	genvar gi;
	generate
		for (gi = 0; gi < ebc_pkg::AREAS; gi++)
		begin : g_sel
			if (gi < ebc_pkg::FIXED_SEL)
				assign sel_en[gi] = 1'b1;
			else
				assign sel_en[gi] = area_select_output_enable_reg[gi];
		end
	endgenerate

	always_ff @(posedge CLK_I or negedge rst_n)
		if (!rst_n)
		begin
			EXT_ADDR_O             <= '0;
			EXT_OE_O               <= 1'b1;
			DATA_O                 <= '0;
			DATA_OE_O              <= 1'b0;
			AREA_SEL_N_O           <= '1;
			ADDR_STROBE_N_O        <= 1'b1;
			READ_STROBE_N_O        <= 1'b1;
			UPPER_WRITE_STROBE_N_O <= 1'b1;
			LOWER_WRITE_STROBE_N_O <= 1'b1;
			BUS_ACK_N_O            <= 1'b1;
			BUS8_MODE_O            <= 1'b1;
		end
		else
		begin
			EXT_ADDR_O <= {cur_addr[23:1], narrow & !hi_next};
			EXT_OE_O    <= (st_next != ebc_pkg::S_REL);
			BUS_ACK_N_O <= (st_next != ebc_pkg::S_REL);
			DATA_O    <= narrow ? {hi_next ? cur_wdata[15:8] : cur_wdata[7:0], ebc_pkg::BYTE_ZERO} :
				cur_wdata;
			DATA_OE_O <= act & cur_wr;
			AREA_SEL_N_O    <= ~({ebc_pkg::AREAS{act}} & sel_en & (8'h01 << area));
			ADDR_STROBE_N_O <= !act;
			READ_STROBE_N_O <= !(act & !cur_wr);
			UPPER_WRITE_STROBE_N_O <= !(wstb & (narrow | cur_be[1]));
			LOWER_WRITE_STROBE_N_O <= !(wstb & !narrow & cur_be[0]);
			BUS8_MODE_O <= (area_bus_width_reg == ebc_pkg::ABW_ALL_8);
		end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!rst_n);

	property p_one_owner;
		$onehot0({MST_GNT_O, !BUS_ACK_N_O});
	endproperty
	a_one_owner: assert property (p_one_owner) else $error("two bus owners");

	property p_float;
		!BUS_ACK_N_O |-> !EXT_OE_O && !DATA_OE_O;
	endproperty
	a_float: assert property (p_float) else $error("pins driven while released");

	property p_permit;
		$fell(BUS_ACK_N_O) |-> $past(release_permit_bit, 1);
	endproperty
	a_permit: assert property (p_permit) else $error("release without permit");

	property p_strobe;
		st_reg == ebc_pkg::S_T1 |-> !ADDR_STROBE_N_O && (READ_STROBE_N_O == lat_wr_reg);
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobes wrong in first state");

	property p_two;
		st_reg == ebc_pkg::S_T2 && !three |=> st_reg != ebc_pkg::S_TW && st_reg != ebc_pkg::S_T3;
	endproperty
	a_two: assert property (p_two) else $error("two-state cycle stretched");

	property p_prog3;
		st_reg == ebc_pkg::S_T2 && three && wait_control_enable_reg[area] &&
			wait_scheme_field == ebc_pkg::WS_PROG && wait_count_field == 2'h3
			|=> st_reg == ebc_pkg::S_TW [*3] ##1 st_reg == ebc_pkg::S_T3;
	endproperty
	a_prog3: assert property (p_prog3) else $error("not three wait states");

	property p_sel;
		st_reg == ebc_pkg::S_T1 && area < 3'h4 |-> !AREA_SEL_N_O[area];
	endproperty
	a_sel: assert property (p_sel) else $error("area select missing");

	property p_narrow_lo;
		st_reg == ebc_pkg::S_T2 && narrow |-> LOWER_WRITE_STROBE_N_O;
	endproperty
	a_narrow_lo: assert property (p_narrow_lo) else $error("lower strobe in 8-bit area");

	property p_bus8;
		1'b1 |=> BUS8_MODE_O == (&$past(area_bus_width_reg));
	endproperty
	a_bus8: assert property (p_bus8) else $error("bus mode flag wrong");

endmodule : ebc_ctrl
`default_nettype wire

// File: bench/ebc_ext_dev.sv
// External device model: read data and wait requests
`timescale 1ns/100ps
`default_nettype none
// ****
// Device model
// ****
module ebc_ext_dev (
	input  wire logic        clk_i,
	input  wire logic [23:0] addr_i,
	input  wire logic        rd_n_i,
	input  wire logic        hold_i,
	output logic      [15:0] data_o,
	output logic             wait_n_o
);
	logic [15:0] last_reg = 16'h0;
	logic [2:0]  cnt_reg  = 3'h0;
	always_ff @(posedge clk_i)
		last_reg <= data_o;
	always_ff @(posedge clk_i)
		cnt_reg <= rd_n_i ? 3'h0 : cnt_reg + 3'h1;
	// Idle lines toggle, so no stale word passes as read data
	assign data_o = rd_n_i ? ~last_reg : addr_i[15:0] ^ 16'h5a3c;
	// Asked ahead of the strobe: the controller sees the pin two edges late
	assign wait_n_o = !(hold_i && cnt_reg < 3'h4);
endmodule : ebc_ext_dev
`default_nettype wire

// File: bench/ebc_ctrl_test.sv
// Testbench of the external bus area controller
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench
// ****
module ebc_ctrl_test;
	logic CLK_I=0,RST_N_I=0,HW_STBY_N_I=1,ACC_WR_I=0,ACC_DONE_O,EXT_OE_O,DATA_OE_O,ADDR_STROBE_N_O,READ_STROBE_N_O;
	logic UPPER_WRITE_STROBE_N_O,LOWER_WRITE_STROBE_N_O,WAIT_N_I,BUS_REQUEST_IN_N_I=1,BUS_ACK_N_O,BUS8_MODE_O;
	logic S_AXI_AWVALID_I=0,S_AXI_AWREADY_O,S_AXI_WVALID_I=0,S_AXI_WREADY_O,S_AXI_BVALID_O,S_AXI_BREADY_I=0;
	logic S_AXI_ARVALID_I=0,S_AXI_ARREADY_O,S_AXI_RVALID_O,S_AXI_RREADY_I=0,hold=0;
	logic [1:0]  ACC_BE_I=2'h3,S_AXI_BRESP_O,S_AXI_RRESP_O;
	logic [2:0]  MODE_I=3'h5,MST_REQ_I=3'h0,MST_GNT_O;
	logic [3:0]  S_AXI_WSTRB_I=4'hf;
	logic [7:0]  AREA_SEL_N_O;
	logic [15:0] ACC_WDATA_I=16'h0,ACC_RDATA_O,DATA_O,DATA_I;
	logic [23:0] ACC_ADDR_I=24'h0,EXT_ADDR_O;
	logic [31:0] S_AXI_AWADDR_I=0,S_AXI_WDATA_I=0,S_AXI_ARADDR_I=0,S_AXI_RDATA_O,n_as,n_rd,n_hw,n_lw,sel,dq;
	int          num_errors=0,n_compared=0,cyc=0;
	ebc_ctrl u_dut (.*);
	ebc_ext_dev u_dev (.clk_i(CLK_I),.addr_i(EXT_ADDR_O),.rd_n_i(READ_STROBE_N_O),.hold_i(hold),.data_o(DATA_I),
		.wait_n_o(WAIT_N_I));
	initial forever #20 CLK_I = ~CLK_I;
	task print_verdict;
		num_errors += (cyc > 30000);
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	// Every wait goes through here, so a hang ends the run
	task tick;
		@(posedge CLK_I);
		cyc++;
		if (cyc > 30000)
			print_verdict;
	endtask : tick
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		num_errors += (g !== e);
		if (g !== e)
			$display("Error %s: expected %h, seen %h", s, e, g);
	endtask : chk
	task wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r);
		logic ad, dd;
		ad = 0;
		dd = 0;
		S_AXI_AWADDR_I <= a;
		S_AXI_WDATA_I <= {24'h0, d};
		S_AXI_AWVALID_I <= 1'b1;
		S_AXI_WVALID_I <= 1'b1;
		while (!(ad && dd))
		begin
			tick;
			ad |= S_AXI_AWREADY_O;
			dd |= S_AXI_WREADY_O;
			S_AXI_AWVALID_I <= !ad;
			S_AXI_WVALID_I <= !dd;
		end
		S_AXI_BREADY_I <= 1'b1;
		do tick; while (S_AXI_BVALID_O !== 1'b1);
		S_AXI_BREADY_I <= 1'b0;
		chk("bresp", {30'h0, r}, {30'h0, S_AXI_BRESP_O});
	endtask : wr
	task rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] r);
		S_AXI_ARADDR_I <= a;
		S_AXI_ARVALID_I <= 1'b1;
		do tick; while (S_AXI_ARREADY_O !== 1'b1);
		S_AXI_ARVALID_I <= 1'b0;
		S_AXI_RREADY_I <= 1'b1;
		do tick; while (S_AXI_RVALID_O !== 1'b1);
		S_AXI_RREADY_I <= 1'b0;
		chk("rdata", {24'h0, e}, S_AXI_RDATA_O);
		chk("rresp", {30'h0, r}, {30'h0, S_AXI_RRESP_O});
	endtask : rd
	task acc(input logic [23:0] a, input logic w, input logic [1:0] be, input logic [15:0] e);
		n_as = 0;
		n_rd = 0;
		n_hw = 0;
		n_lw = 0;
		MST_REQ_I <= 3'h1;
		ACC_ADDR_I <= a;
		ACC_WR_I <= w;
		ACC_BE_I <= be;
		ACC_WDATA_I <= e;
		do
		begin
			tick;
			n_as += !ADDR_STROBE_N_O;
			n_rd += !READ_STROBE_N_O;
			n_hw += !UPPER_WRITE_STROBE_N_O;
			n_lw += !LOWER_WRITE_STROBE_N_O;
			if (!LOWER_WRITE_STROBE_N_O && n_lw == 1)
				dq = {16'h0, DATA_O};
			if (!ADDR_STROBE_N_O)
				sel = {24'h0, AREA_SEL_N_O};
		end
		while (ACC_DONE_O !== 1'b1);
		chk("gnt", 32'h1, {29'h0, MST_GNT_O});
		MST_REQ_I <= 3'h0;
		if (!w)
			chk("acc_rdata", {16'h0, e}, {16'h0, ACC_RDATA_O});
		tick;
	endtask : acc
	task t_regs;
		rd(32'h3ffb0, 8'hff, 2'h0);
		rd(32'h3ffb4, 8'hff, 2'h0);
		rd(32'h3ffb8, 8'hf3, 2'h0);
		rd(32'h3ffbc, 8'hff, 2'h0);
		rd(32'h3ffcc, 8'hfe, 2'h0);
		rd(32'h3fd7c, 8'h0f, 2'h0);
		chk("bus8", 32'h1, {31'h0, BUS8_MODE_O});
		wr(32'h3ffb0, 8'hfd, 2'h0);
		tick;
		chk("bus8", 32'h0, {31'h0, BUS8_MODE_O});
		rd(32'h3ff00, 8'h00, 2'h2);
		wr(32'h3ff00, 8'h00, 2'h2);
	endtask : t_regs
	task t_states;
		logic [7:0] cfg [7];
		logic [31:0] ex [7];
		cfg = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf7, 8'hf9, 8'hfd};
		ex = '{32'h3, 32'h4, 32'h5, 32'h6, 32'h3, 32'h4, 32'h3};
		wr(32'h3ffb4, 8'h00, 2'h0);
		acc(24'h200100, 1'b0, 2'h3, 16'h5b3c);
		chk("as", 32'h2, n_as);
		chk("rd", 32'h2, n_rd);
		chk("sel", 32'hfd, sel);
		acc(24'h200102, 1'b1, 2'h1, 16'h00c3);
		chk("lw", 32'h1, {31'h0, n_lw != 0});
		chk("data", 32'h00c3, dq);
		chk("hw", 32'h0, {31'h0, n_hw != 0});
		wr(32'h3ffb4, 8'hff, 2'h0);
		for (int i = 0; i < 7; i++)
		begin
			wr(32'h3ffb8, cfg[i], 2'h0);
			acc(24'h200100, 1'b0, 2'h3, 16'h5b3c);
			chk("states", ex[i], n_as);
		end
		acc(24'h000100, 1'b1, 2'h3, 16'ha55a);
		chk("hw8", 32'h4, n_hw);
		chk("lw8", 32'h0, n_lw);
		hold <= 1'b1;
		wr(32'h3ffb8, 8'hfd, 2'h0);
		acc(24'h200100, 1'b0, 2'h3, 16'h5b3c);
		chk("auto", 32'h4, n_as);
		wr(32'h3ffb8, 8'hf0, 2'h0);
		wr(32'h3ffbc, 8'hfd, 2'h0);
		acc(24'h200100, 1'b0, 2'h3, 16'h5b3c);
		hold <= 1'b0;
		chk("stretch", 32'h1, {31'h0, n_as > 32'h3});
	endtask : t_states
	task t_release;
		BUS_REQUEST_IN_N_I <= 1'b0;
		repeat (8) tick;
		chk("ack", 32'h1, {31'h0, BUS_ACK_N_O});
		wr(32'h3ffcc, 8'hff, 2'h0);
		repeat (8) tick;
		chk("ack", 32'h0, {31'h0, BUS_ACK_N_O});
		chk("oe", 32'h0, {31'h0, EXT_OE_O});
		chk("doe", 32'h0, {31'h0, DATA_OE_O});
		BUS_REQUEST_IN_N_I <= 1'b1;
		repeat (8) tick;
		chk("ack", 32'h1, {31'h0, BUS_ACK_N_O});
		chk("oe", 32'h1, {31'h0, EXT_OE_O});
	endtask : t_release
	task t_stby;
		MODE_I <= 3'h4;
		HW_STBY_N_I <= 1'b0;
		repeat (4) tick;
		HW_STBY_N_I <= 1'b1;
		repeat (4) tick;
		rd(32'h3ffb0, 8'h00, 2'h0);
		rd(32'h3ffcc, 8'hfe, 2'h0);
		chk("bus8", 32'h0, {31'h0, BUS8_MODE_O});
	endtask : t_stby
	initial
	begin
		repeat (6) tick;
		RST_N_I <= 1'b1;
		repeat (6) tick;
		t_regs;
		t_states;
		t_release;
		t_stby;
		print_verdict;
	end
endmodule : ebc_ctrl_test
`default_nettype wire
